// file: design/pfpc_top.sv
// pfpc_top: pad function and pull control for port d, port e and the
// boundary-scan test pins.
// assumes config ports come from same-clock software registers; pins and
// test pins are asynchronous and synchronised here.
// Functional notes
// - port d pins 0..5 each input or output
// - pins 0..5 alternate as active-low selects
// - bus drive bit decides idle select float
// - reset leaves pins 0..5 in gpio mode
// - clear port d pull bit n releases pin
// - reset gives port e pin 0 to tx0
// - clear port e pull bit 0 releases tx0
// - reset gives port e pin 1 to rx0
// - clear port e pull bit 1 releases rx0
// - reset gives port d pin 6 to tx1
// - reset gives port d pin 7 to rx1
// - test clock input with internal pull-down
// - test mode sampled on rising test clock
// - test data captured on rising test clock
// - test pull-ups stay until disable bit set
// - test output driven only in shift states
// - test output changes on falling test clock
// - peripheral enable hands pin to peripheral
`timescale 1ns/1ps
module pfpc_top
   import pfpc_pkg::*;
#(
   parameter int PD_W = PFPC_PD_PINS,
   parameter int PE_W = PFPC_PE_PINS,
   parameter int CS_W = PFPC_PD_GPIO_PINS
) (
   input  wire logic            sys_clk_in,
   input  wire logic            arst_n_in,
   // software configuration
   input  wire logic [PD_W-1:0] port_d_per_in,
   input  wire logic [PD_W-1:0] port_d_pullup_register_in,
   input  wire logic [PD_W-1:0] port_d_ddr_in,
   input  wire logic [PD_W-1:0] port_d_dout_in,
   input  wire logic [PE_W-1:0] port_e_per_in,
   input  wire logic [PE_W-1:0] port_e_pullup_register_in,
   input  wire logic [PE_W-1:0] port_e_ddr_in,
   input  wire logic [PE_W-1:0] port_e_dout_in,
   input  wire logic            cfg_load_in,
   input  wire logic            test_pullup_disable_in,
   input  wire logic            bus_drive_select_in,
   // memory interface side
   input  wire logic [CS_W-1:0] ext_select_n_in,
   input  wire logic            ext_bus_active_in,
   // serial engines
   input  wire logic            serial0_tx_in,
   input  wire logic            serial1_tx_in,
   output logic                 serial0_rx_out,
   output logic                 serial1_rx_out,
   // gpio read-back
   output logic [PD_W-1:0]      port_d_din_out,
   output logic [PE_W-1:0]      port_e_din_out,
   // port pads
   input  wire logic [PD_W-1:0] port_d_pad_in,
   output logic [PD_W-1:0]      port_d_pad_out,
   output logic [PD_W-1:0]      port_d_pad_oe_out,
   output logic [PD_W-1:0]      port_d_pad_pu_out,
   input  wire logic [PE_W-1:0] port_e_pad_in,
   output logic [PE_W-1:0]      port_e_pad_out,
   output logic [PE_W-1:0]      port_e_pad_oe_out,
   output logic [PE_W-1:0]      port_e_pad_pu_out,
   // test pins
   input  wire logic            tck_pad_in,
   input  wire logic            tms_pad_in,
   input  wire logic            tdi_pad_in,
   input  wire logic            trst_n_pad_in,
   output logic                 tck_pad_pd_out,
   output logic                 tms_pad_pu_out,
   output logic                 tdi_pad_pu_out,
   output logic                 tdo_pad_out,
   output logic                 tdo_pad_oe_out,
   input  wire logic            test_tdo_data_in,
   output logic                 test_tdi_out,
   output logic                 test_tdi_valid_out,
   output logic                 test_shifting_out
);

////////////////////////////////////////////////////////////////////////////
   logic [1:0] rst_sync_q;
   logic       rst_n;
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

////////////////////////////////////////////////////////////////////////////
   // configuration held in flops so reset defaults are guaranteed
   logic [PD_W-1:0] pd_per_q, pd_pur_q, pd_ddr_q, pd_dout_q;
   logic [PE_W-1:0] pe_per_q, pe_pur_q, pe_ddr_q, pe_dout_q;
   logic            test_pud_q, drv_q;
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         pd_per_q   <= PFPC_PD_PER_RST;
         pd_pur_q   <= PFPC_PD_PUR_RST;
         pd_ddr_q   <= PFPC_PD_DDR_RST;
         pd_dout_q  <= PFPC_PD_DOUT_RST;
         pe_per_q   <= PFPC_PE_PER_RST;
         pe_pur_q   <= PFPC_PE_PUR_RST;
         pe_ddr_q   <= PFPC_PE_DDR_RST;
         pe_dout_q  <= PFPC_PE_DOUT_RST;
         test_pud_q <= 1'b0;
         drv_q      <= 1'b0;
      end else if (cfg_load_in) begin
         pd_per_q   <= port_d_per_in;
         pd_pur_q   <= port_d_pullup_register_in;
         pd_ddr_q   <= port_d_ddr_in;
         pd_dout_q  <= port_d_dout_in;
         pe_per_q   <= port_e_per_in;
         pe_pur_q   <= port_e_pullup_register_in;
         pe_ddr_q   <= port_e_ddr_in;
         pe_dout_q  <= port_e_dout_in;
         test_pud_q <= test_pullup_disable_in;
         drv_q      <= bus_drive_select_in;
      end
   end

////////////////////////////////////////////////////////////////////////////
   // pad input synchronisers
   logic [PD_W-1:0] pd_in_s;
   logic [PE_W-1:0] pe_in_s;
   logic [3:0]      tst_s;
   pfpc_sync #(.W(PD_W)) u_sync_d (
      .clk_in   (sys_clk_in),
      .rst_n_in (rst_n),
      .d_in     (port_d_pad_in),
      .q_out    (pd_in_s)
   );
   pfpc_sync #(.W(PE_W)) u_sync_e (
      .clk_in   (sys_clk_in),
      .rst_n_in (rst_n),
      .d_in     (port_e_pad_in),
      .q_out    (pe_in_s)
   );
   pfpc_sync #(.W(4)) u_sync_t (
      .clk_in   (sys_clk_in),
      .rst_n_in (rst_n),
      .d_in     ({trst_n_pad_in, tdi_pad_in, tms_pad_in, tck_pad_in}),
      .q_out    (tst_s)
   );

////////////////////////////////////////////////////////////////////////////
   // port d: pins 0..5 alternate is memory select, 6 tx1, 7 rx1 (input)
   logic [PD_W-1:0] pd_alt_o, pd_alt_oe, pd_o, pd_oe;
   logic            cs_drive;
   // idle selects float only when bus drive is cleared
   assign cs_drive = ext_bus_active_in | drv_q;
   genvar gi;
   generate
      for (gi = 0; gi < PD_W; gi++) begin : g_pd
         if (gi < CS_W) begin : g_cs
            assign pd_alt_o[gi]  = ext_select_n_in[gi];
            assign pd_alt_oe[gi] = cs_drive;
         end else if (gi == PFPC_PD_TX1_BIT) begin : g_tx
            assign pd_alt_o[gi]  = serial1_tx_in;
            assign pd_alt_oe[gi] = 1'b1;
         end else begin : g_rx
            assign pd_alt_o[gi]  = 1'b1;
            assign pd_alt_oe[gi] = 1'b0;
         end
         assign pd_o[gi]  = pd_per_q[gi] ? pd_alt_o[gi]  : pd_dout_q[gi];
         assign pd_oe[gi] = pd_per_q[gi] ? pd_alt_oe[gi] : pd_ddr_q[gi];
      end
   endgenerate
   assign port_d_pad_out    = pd_o;
   assign port_d_pad_oe_out = rst_n ? pd_oe : '0;
   assign port_d_pad_pu_out = rst_n ? pd_pur_q : '1;
   assign port_d_din_out    = pd_in_s;
   assign serial1_rx_out    = pd_per_q[PFPC_PD_RX1_BIT] ?
                              pd_in_s[PFPC_PD_RX1_BIT] : 1'b1;

////////////////////////////////////////////////////////////////////////////
   // port e: pin 0 tx0, pin 1 rx0
   logic [PE_W-1:0] pe_alt_o, pe_alt_oe, pe_o, pe_oe;
   assign pe_alt_o  = {1'b1, serial0_tx_in};
   assign pe_alt_oe = {1'b0, 1'b1};
   assign pe_o      = (pe_per_q & pe_alt_o) | (~pe_per_q & pe_dout_q);
   assign pe_oe     = (pe_per_q & pe_alt_oe) | (~pe_per_q & pe_ddr_q);
   assign port_e_pad_out    = pe_o;
   assign port_e_pad_oe_out = rst_n ? pe_oe : '0;
   assign port_e_pad_pu_out = rst_n ? pe_pur_q : '1;
   assign port_e_din_out    = pe_in_s;
   assign serial0_rx_out    = pe_per_q[PFPC_PE_RX0_BIT] ?
                              pe_in_s[PFPC_PE_RX0_BIT] : 1'b1;

////////////////////////////////////////////////////////////////////////////
   // test pins: test clock sampled in system domain, so it must run well
   // below a quarter of sys_clk for edges to be seen
   logic tck_q, tdo_q, tdi_q, tdi_v_q;
   logic tck_rise, tck_fall, shifting;
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         tck_q   <= 1'b0;
         tdo_q   <= 1'b0;
         tdi_q   <= 1'b0;
         tdi_v_q <= 1'b0;
      end else begin
         tck_q   <= tst_s[0];
         tdi_v_q <= tck_rise;
         if (tck_rise) begin
            tdi_q <= tst_s[2];
         end
         if (tck_fall) begin
            tdo_q <= test_tdo_data_in;
         end
      end
   end
   assign tck_rise = tst_s[0] & ~tck_q;
   assign tck_fall = ~tst_s[0] & tck_q;
   pfpc_tap_fsm u_tap (
      .clk_in       (sys_clk_in),
      .rst_n_in     (rst_n),
      .trst_n_in    (tst_s[3]),
      .rise_in      (tck_rise),
      .tms_in       (tst_s[1]),
      .shifting_out (shifting)
   );
   assign tck_pad_pd_out     = 1'b1;
   assign tms_pad_pu_out     = ~(rst_n & test_pud_q);
   assign tdi_pad_pu_out     = ~(rst_n & test_pud_q);
   assign tdo_pad_out        = tdo_q;
   assign tdo_pad_oe_out     = rst_n & shifting;
   assign test_tdi_out       = tdi_q;
   assign test_tdi_valid_out = tdi_v_q;
   assign test_shifting_out  = shifting;

////////////////////////////////////////////////////////////////////////////
   a_reset_drivers_off: assert property (
      @(posedge sys_clk_in) !rst_n |-> (port_d_pad_oe_out == '0 &&
      port_e_pad_oe_out == '0 && port_d_pad_pu_out == '1 &&
      port_e_pad_pu_out == '1 && !tdo_pad_oe_out))
      else $error("drivers active in reset");
   a_tdo_only_shift: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n)
      tdo_pad_oe_out |-> shifting)
      else $error("tdo driven outside shift");
   a_tdo_on_fall: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n)
      !tck_fall |=> $stable(tdo_pad_out))
      else $error("tdo changed off falling edge");
   a_tdi_on_rise: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n)
      tck_rise |=> (test_tdi_out == $past(tst_s[2]) && test_tdi_valid_out))
      else $error("tdi not captured on rise");
   a_test_pull_kept: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n)
      !test_pud_q |-> (tms_pad_pu_out && tdi_pad_pu_out))
      else $error("test pull-up dropped");
   a_cs_float_idle: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n)
      (pd_per_q[0] && !drv_q && !ext_bus_active_in) |-> !port_d_pad_oe_out[0])
      else $error("idle select driven");
   a_pd_pull_clear: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n)
      (cfg_load_in && !port_d_pullup_register_in[0]) |=> !port_d_pad_pu_out[0])
      else $error("pull-up not released");
   a_reset_defaults: assert property (
      @(posedge sys_clk_in) $rose(rst_n) |-> (pd_per_q == PFPC_PD_PER_RST &&
      pe_per_q == PFPC_PE_PER_RST))
      else $error("wrong reset pin ownership");
   a_gpio_mux: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n)
      !pe_per_q[0] |-> (port_e_pad_out[0] == pe_dout_q[0] &&
      port_e_pad_oe_out[0] == pe_ddr_q[0]))
      else $error("gpio mux wrong");
   // test-port steps as named sequences, each used by one of the two properties below
   sequence s_trst_held;
      !tst_s[3];
   endsequence
   sequence s_no_tck_step;
      !tck_rise && tst_s[3];
   endsequence
   a_trst_idle: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n)
      s_trst_held |=> !test_shifting_out)
      else $error("test reset left shift state");
   a_tms_on_rise: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n)
      s_no_tck_step |=> $stable(test_shifting_out))
      else $error("tap stepped without test clock rise");
   a_tdi_valid_once: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n)
      !tck_rise |=> !test_tdi_valid_out)
      else $error("tdi valid without rise");
   a_gpio_dir: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n)
      ((~pd_per_q & (port_d_pad_oe_out ^ pd_ddr_q)) == '0) &&
      ((~pd_per_q & (port_d_pad_out ^ pd_dout_q)) == '0))
      else $error("gpio direction or value not honoured");
   a_select_value: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n)
      ((pd_per_q[CS_W-1:0] &
      (port_d_pad_out[CS_W-1:0] ^ ext_select_n_in)) == '0))
      else $error("select value not passed");
   a_select_drive: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n)
      (pd_per_q[0] && (drv_q || ext_bus_active_in)) |->
      port_d_pad_oe_out[0])
      else $error("active select not driven");
   a_tx_own_pins: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n)
      (pd_per_q[PFPC_PD_TX1_BIT] && pe_per_q[PFPC_PE_TX0_BIT]) |->
      (port_d_pad_out[PFPC_PD_TX1_BIT] == serial1_tx_in &&
      port_e_pad_out[PFPC_PE_TX0_BIT] == serial0_tx_in &&
      port_d_pad_oe_out[PFPC_PD_TX1_BIT] &&
      port_e_pad_oe_out[PFPC_PE_TX0_BIT]))
      else $error("transmit pin not owned");
   a_rx_pins_input: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n)
      pd_per_q[PFPC_PD_RX1_BIT] |-> !port_d_pad_oe_out[PFPC_PD_RX1_BIT])
      else $error("receive pin driven");
   a_pe_pull_clear: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n)
      cfg_load_in |=> port_e_pad_pu_out == $past(port_e_pullup_register_in))
      else $error("port e pull-up not set");
endmodule : pfpc_top

// file: design/pfpc_pkg.sv
// pfpc_pkg: shared constants for the pad function and pull control block.
// assumes a single 125 MHz system clock domain.
package pfpc_pkg;
   localparam int PFPC_PD_GPIO_PINS   = 6;
   localparam int PFPC_PD_PINS        = 8;
   localparam int PFPC_PE_PINS        = 2;
   localparam int PFPC_PD_TX1_BIT     = 6;
   localparam int PFPC_PD_RX1_BIT     = 7;
   localparam int PFPC_PE_TX0_BIT     = 0;
   localparam int PFPC_PE_RX0_BIT     = 1;
   localparam int PFPC_SYNC_STAGES    = 2;
   // peripheral enable reset values: port d pins 0..5 gpio, 6..7 serial
   localparam logic [7:0] PFPC_PD_PER_RST  = 8'hC0;
   localparam logic [1:0] PFPC_PE_PER_RST  = 2'h3;
   localparam logic [7:0] PFPC_PD_PUR_RST  = 8'hFF;
   localparam logic [1:0] PFPC_PE_PUR_RST  = 2'h3;
   localparam logic [7:0] PFPC_PD_DDR_RST  = 8'h00;
   localparam logic [1:0] PFPC_PE_DDR_RST  = 2'h0;
   localparam logic [7:0] PFPC_PD_DOUT_RST = 8'h00;
   localparam logic [1:0] PFPC_PE_DOUT_RST = 2'h0;
   // test access port states, one-hot
   typedef enum logic [15:0] {
      PFPC_TLR  = 16'h0001, PFPC_RTI  = 16'h0002,
      PFPC_SDRS = 16'h0004, PFPC_CDR  = 16'h0008,
      PFPC_SDR  = 16'h0010, PFPC_E1DR = 16'h0020,
      PFPC_PDR  = 16'h0040, PFPC_E2DR = 16'h0080,
      PFPC_UDR  = 16'h0100, PFPC_SIRS = 16'h0200,
      PFPC_CIR  = 16'h0400, PFPC_SIR  = 16'h0800,
      PFPC_E1IR = 16'h1000, PFPC_PIR  = 16'h2000,
      PFPC_E2IR = 16'h4000, PFPC_UIR  = 16'h8000
   } pfpc_tap_state_t;
endpackage : pfpc_pkg

// file: design/pfpc_sync.sv
// pfpc_sync: two flip-flop level synchroniser for a vector of pins.
// assumes inputs are asynchronous to sys_clk_in.
`timescale 1ns/1ps
module pfpc_sync
   import pfpc_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d_in;
         sync_q <= meta_q;
      end
   end
   assign q_out = sync_q;
endmodule : pfpc_sync

// file: design/pfpc_tap_fsm.sv
// pfpc_tap_fsm: test access port sequencer stepped by sampled test clock
// edges; only its shift states matter for the test data output enable.
// assumes tck/tms already synchronised and edge-detected by the caller.
`timescale 1ns/1ps
module pfpc_tap_fsm
   import pfpc_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic trst_n_in,
   input  wire logic rise_in,
   input  wire logic tms_in,
   output logic      shifting_out
);
   pfpc_tap_state_t st_q;
   pfpc_tap_state_t st_d;
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         PFPC_TLR:  st_d = tms_in ? PFPC_TLR  : PFPC_RTI;
         PFPC_RTI:  st_d = tms_in ? PFPC_SDRS : PFPC_RTI;
         PFPC_SDRS: st_d = tms_in ? PFPC_SIRS : PFPC_CDR;
         PFPC_CDR:  st_d = tms_in ? PFPC_E1DR : PFPC_SDR;
         PFPC_SDR:  st_d = tms_in ? PFPC_E1DR : PFPC_SDR;
         PFPC_E1DR: st_d = tms_in ? PFPC_UDR  : PFPC_PDR;
         PFPC_PDR:  st_d = tms_in ? PFPC_E2DR : PFPC_PDR;
         PFPC_E2DR: st_d = tms_in ? PFPC_UDR  : PFPC_SDR;
         PFPC_UDR:  st_d = tms_in ? PFPC_SDRS : PFPC_RTI;
         PFPC_SIRS: st_d = tms_in ? PFPC_TLR  : PFPC_CIR;
         PFPC_CIR:  st_d = tms_in ? PFPC_E1IR : PFPC_SIR;
         PFPC_SIR:  st_d = tms_in ? PFPC_E1IR : PFPC_SIR;
         PFPC_E1IR: st_d = tms_in ? PFPC_UIR  : PFPC_PIR;
         PFPC_PIR:  st_d = tms_in ? PFPC_E2IR : PFPC_PIR;
         PFPC_E2IR: st_d = tms_in ? PFPC_UIR  : PFPC_SIR;
         PFPC_UIR:  st_d = tms_in ? PFPC_SDRS : PFPC_RTI;
         default:   st_d = PFPC_TLR;
      endcase
   end
   // tms sampled only on a rising test clock edge
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q <= PFPC_TLR;
      end else if (!trst_n_in) begin
         st_q <= PFPC_TLR;
      end else if (rise_in) begin
         st_q <= st_d;
      end
   end
   assign shifting_out = (st_q == PFPC_SDR) || (st_q == PFPC_SIR);
endmodule : pfpc_tap_fsm

// file: verif/pfpc_pad_model.sv
// pfpc_pad_model: far side of the pads, pin loads and a test port debugger.
// assumes the bench calls drive() just after a rising sys_clk_in edge.
`timescale 1ns/1ps
module pfpc_pad_model (
   input  wire logic       clk_in,
   input  wire logic [9:0] out_in,
   input  wire logic [9:0] oe_in,
   input  wire logic [9:0] pu_in,
   input  wire logic [9:0] ext_in,
   input  wire logic [9:0] ext_en_in,
   output logic      [9:0] wire_out,
   output logic            tck_out,
   output logic            tms_out,
   output logic            tdi_out,
   output logic            trst_n_out
);
   localparam int HALF = 6;
   logic [9:0] tgl_q = 10'h155;
   initial begin
      tck_out    = 1'b0;
      tms_out    = 1'b1;
      tdi_out    = 1'b1;
      trst_n_out = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////
   // an undriven pin without pull-up gets a changing level, never a
   // stale one, so a missing pull-up cannot hide behind the last value
   always_ff @(posedge clk_in) tgl_q <= ~tgl_q;
   assign wire_out = (oe_in & out_in) | (~oe_in & ext_en_in & ext_in)
                   | (~oe_in & ~ext_en_in & (pu_in | tgl_q));
   ////////////////////////////////////////////////////////////////////////
   // one test clock phase; tck stands low between frames
   task automatic drive(input logic c, input logic m, input logic d);
      tck_out <= c;
      tms_out <= m;
      tdi_out <= d;
      repeat (HALF - 1) @(posedge clk_in);
   endtask : drive
   // test reset pin level, held for one test clock phase
   task automatic hold_trst(input logic v);
      trst_n_out <= v;
      repeat (HALF - 1) @(posedge clk_in);
   endtask : hold_trst
endmodule : pfpc_pad_model

// file: verif/pad_function_and_pull_control_tb_top.sv
// pad_function_and_pull_control_tb_top: self-checking bench for pfpc_top.
// assumes the pad model resolves every pin and plays the debugger.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
   $display("FAIL %s exp %h got %h", nm, e, g); end end
module pad_function_and_pull_control_tb_top;
   import pfpc_pkg::*;
   logic       clk = 1'b0, rst_n = 1'b0, load, tpd, drv, act, tx0, tx1, tdo_d;
   logic [9:0] per, pur, ddr, dout, ext;
   logic [5:0] sel;
   logic [31:0] rs = 32'h56AFBE4A;
   int         checks = 0, failures = 0, rises = 0, vcnt = 0;
   wire  [9:0] pout, poe, ppu, din, wl;
   wire        rx0, rx1, tck, tms, tdi, trst_n, tck_pd, tms_pu, tdi_pu;
   wire        tdo, tdo_oe, tdi_o, tdi_v, shf;
   always #4 clk = ~clk;
   always @(posedge clk) if (tdi_v === 1'b1) vcnt <= vcnt + 1;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   function automatic logic [9:0] e_oe();
      return (~per & ddr) | (per & {1'b0, 1'b1, 1'b0, 1'b1, {6{act | drv}}});
   endfunction : e_oe
   function automatic logic [9:0] e_out();
      return (~per & dout) | (per & {1'b0, tx0, 1'b0, tx1, sel});
   endfunction : e_out
   // the far side drives only pins the block leaves floating
   // a process, not an assign: the function reads bench state directly
   logic [9:0] ext_en;
   always_comb ext_en = ~e_oe();
   pfpc_top dut_u (.sys_clk_in(clk), .arst_n_in(rst_n),
      .port_d_per_in(per[7:0]), .port_d_pullup_register_in(pur[7:0]),
      .port_d_ddr_in(ddr[7:0]), .port_d_dout_in(dout[7:0]),
      .port_e_per_in(per[9:8]), .port_e_pullup_register_in(pur[9:8]),
      .port_e_ddr_in(ddr[9:8]), .port_e_dout_in(dout[9:8]),
      .cfg_load_in(load), .test_pullup_disable_in(tpd),
      .bus_drive_select_in(drv), .ext_select_n_in(sel),
      .ext_bus_active_in(act), .serial0_tx_in(tx0), .serial1_tx_in(tx1),
      .serial0_rx_out(rx0), .serial1_rx_out(rx1),
      .port_d_din_out(din[7:0]), .port_e_din_out(din[9:8]),
      .port_d_pad_in(wl[7:0]), .port_d_pad_out(pout[7:0]),
      .port_d_pad_oe_out(poe[7:0]), .port_d_pad_pu_out(ppu[7:0]),
      .port_e_pad_in(wl[9:8]), .port_e_pad_out(pout[9:8]),
      .port_e_pad_oe_out(poe[9:8]), .port_e_pad_pu_out(ppu[9:8]),
      .tck_pad_in(tck), .tms_pad_in(tms), .tdi_pad_in(tdi),
      .trst_n_pad_in(trst_n), .tck_pad_pd_out(tck_pd),
      .tms_pad_pu_out(tms_pu), .tdi_pad_pu_out(tdi_pu), .tdo_pad_out(tdo),
      .tdo_pad_oe_out(tdo_oe), .test_tdo_data_in(tdo_d),
      .test_tdi_out(tdi_o), .test_tdi_valid_out(tdi_v),
      .test_shifting_out(shf));
   pfpc_pad_model pm_u (.clk_in(clk), .out_in(pout), .oe_in(poe),
      .pu_in(ppu), .ext_in(ext), .ext_en_in(ext_en), .wire_out(wl),
      .tck_out(tck), .tms_out(tms), .tdi_out(tdi), .trst_n_out(trst_n));
   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run
   // one test clock bit; sf/sa: shifting expected in low / after rise
   task automatic tbit(input logic m, d, t, sf, sa);
      @(posedge clk);
      tdo_d <= t;
      pm_u.drive(1'b0, m, d);
      #1 `CHK("tdo_oe_lo", sf, tdo_oe);
      if (sf) `CHK("tdo", t, tdo);
      @(posedge clk);
      tdo_d <= ~t;
      pm_u.drive(1'b1, m, d);
      rises++;
      #1 `CHK("tdi", d, tdi_o);
      `CHK("shift", sa, shf);
      `CHK("tdo_oe_hi", sa, tdo_oe);
      if (sf) `CHK("tdo_hold", t, tdo);
   endtask : tbit
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      complete_run();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {load, tpd, drv, act, tdo_d} = '0;
      {tx0, tx1} = 2'b11;
      {per, pur, ddr, dout, ext} = '0;
      sel = '0;
      repeat (2) @(posedge clk);
      #1 `CHK("rst_oe", 10'h000, poe);
      `CHK("rst_pu", 10'h3FF, ppu);
      `CHK("rst_tdo_oe", 1'b0, tdo_oe);
      `CHK("tck_pd", 1'b1, tck_pd);
      @(posedge clk) rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1 `CHK("def_oe", 10'h140, poe);
      `CHK("def_tx", 2'b11, {pout[8], pout[6]});
      `CHK("def_rx", 2'b00, {rx0, rx1});
      $display("test reset done");
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         rs = xs(rs);
         per <= i == 0 ? 10'h3FF : i == 1 ? 10'h000 : rs[9:0];
         pur <= i == 0 ? 10'h000 : rs[19:10];
         ddr <= i == 1 ? 10'h3FF : rs[29:20];
         rs = xs(rs);
         dout <= rs[9:0];
         ext <= rs[19:10];
         sel <= rs[25:20];
         {act, drv, tx0, tx1, tpd} <= rs[30:26];
         load <= 1'b1;
         @(posedge clk) load <= 1'b0;
         repeat (3) @(posedge clk);
         #1 `CHK("oe", e_oe(), poe);
         `CHK("out", e_oe() & e_out(), e_oe() & pout);
         `CHK("pu", pur, ppu);
         `CHK("din", (e_oe() & e_out()) | (~e_oe() & ext), din);
         `CHK("rx", {per[9] ? ext[9] : 1'b1, per[7] ? ext[7] : 1'b1},
              {rx0, rx1});
         `CHK("test_pu", {2{~tpd}}, {tms_pu, tdi_pu});
      end
      $display("test config done");
      @(posedge clk) rst_n <= 1'b0;
      @(posedge clk);
      #1 `CHK("mid_oe", 10'h000, poe);
      `CHK("mid_pu", 10'h3FF, ppu);
      @(posedge clk) rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1 `CHK("mid_def", 10'h140, poe & {2'h3, 8'hC0});
      `CHK("mid_test_pu", 2'b11, {tms_pu, tdi_pu});
      $display("test midreset done");
      for (int i = 0; i < 5; i++) tbit(1'b1, i[0], 1'b0, 1'b0, 1'b0);
      tbit(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      tbit(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      tbit(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      tbit(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
      for (int i = 0; i < 8; i++) begin
         rs = xs(rs);
         tbit(i == 7, rs[0], rs[1], 1'b1, i != 7);
      end
      tbit(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      @(posedge clk) pm_u.drive(1'b0, 1'b1, 1'b1);
      `CHK("valid_cnt", rises, vcnt);
      $display("test tap done");
      tbit(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      tbit(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      tbit(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      tbit(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
      @(posedge clk) pm_u.hold_trst(1'b0);
      #1 `CHK("trst_shift", 1'b0, shf);
      `CHK("trst_oe", 1'b0, tdo_oe);
      @(posedge clk) pm_u.hold_trst(1'b1);
      tbit(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      $display("test trst done");
      complete_run();
   end
endmodule : pad_function_and_pull_control_tb_top
